// ---- core/lcd_pkg.sv ----
// Shared constants for the display power control and display buffer.
// Assumes a 10 MHz system clock and a word-wide AHB-Lite register bus.
package lcd_pkg;

  // System clock and the slow clock that is made from it
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int SLOW_HZ = 32_768;
  localparam int SLOW_HALF_CYC = SYS_CLK_HZ / (2 * SLOW_HZ);
  localparam int HALF_W = 8;
  localparam logic [HALF_W-1:0] SLOW_HALF_LAST = HALF_W'(SLOW_HALF_CYC - 1);
  localparam int TAP_W = 8;

  // Register indices; byte address is the index times four
  localparam int IDX_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 13;
  localparam logic [IDX_W-1:0] IDX_POWER_CTRL = 12'h01a;
  localparam logic [IDX_W-1:0] IDX_DISP_BASE = 12'h200;
  localparam logic [IDX_W-1:0] IDX_DISP_TOP = 12'h25f;

  // Power control fields
  localparam int PC_SEL_LSB = 0;
  localparam int PC_SEL_MSB = 2;
  localparam int PC_PUMP_EN = 3;
  localparam int PC_REG_EN = 4;
  localparam int PC_LVL_LSB = 5;
  localparam int PC_LVL_MSB = 6;
  localparam logic [7:0] POWER_CTRL_RESET = 8'h6f;
  localparam logic [7:0] POWER_CTRL_MASK = 8'h7f;
  localparam logic [2:0] PUMP_SEL_DIRECT = 3'h7;
  localparam logic [2:0] PUMP_TAP_TOP = 3'h6;

  // Display buffer geometry
  localparam int BYTES_PER_ROW = 8;
  localparam int COL_W = 64;
  localparam int ROW_W = 4;
  localparam int RAM_AW = 7;
  localparam int MAX_ROWS = 12;
  localparam int MIN_DEPTH = 8;
  localparam int MAX_DEPTH = 96;

  // AHB-Lite
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    SCAN_IDLE = 1'b0,
    SCAN_FILL = 1'b1
  } scan_state_t;

endpackage

// ---- core/display_buffer_ram.sv ----
// Display buffer storage with a processor port and a scanner read port.
// Assumes the owner keeps write addresses inside the implemented depth.
`timescale 1ns/1ns
module display_buffer_ram #(
  parameter int DEPTH = 96
) (
  input wire logic clk_i,
  input wire logic cpu_we_i,
  input wire logic [lcd_pkg::RAM_AW-1:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  input wire logic [lcd_pkg::RAM_AW-1:0] scan_addr_i,
  output logic [7:0] scan_rdata_o
);

  // No reset on purpose: contents are undefined until software writes them
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (cpu_we_i && (int'(cpu_addr_i) < DEPTH)) begin
      mem[cpu_addr_i] <= cpu_wdata_i;
    end
  end

  // Separate read ports, so scanning never holds off the processor
  always_comb begin
    cpu_rdata_o = 8'h00;
    scan_rdata_o = 8'h00;
    if (int'(cpu_addr_i) < DEPTH) begin
      cpu_rdata_o = mem[cpu_addr_i];
    end
    if (int'(scan_addr_i) < DEPTH) begin
      scan_rdata_o = mem[scan_addr_i];
    end
  end

  default clocking @(posedge clk_i); endclocking

  ram_store_a: assert property (
    cpu_we_i && (int'(cpu_addr_i) < DEPTH) |=>
      mem[$past(cpu_addr_i)] == $past(cpu_wdata_i))
    else $error("Buffer write not stored");

endmodule

// ---- core/lcd_power_and_display_ram.sv ----
// Display power control register, charge-pump clock select and buffer scan.
// Assumes one AHB-Lite master doing single word transfers on SYS_CLK_I.
//
// Overview of operation
// - Pump clock from slow divider tap by code
// - Code 111 runs pump from slow clock
// - Bit 3 enables charge pump, default on
// - Bit 4 enables internal regulator
// - Bits 6:5 select regulator level
// - Level steps 0.167 V above 1 V
// - Buffer covers twelve rows, top at 0x25f
// - Buffer depth eight to ninety-six bytes; the code needs at least 16, as ROWS is at least 2
// - Byte k drives column group k
// - Writes anytime, shown from next scan
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module lcd_power_and_display_ram #(
  parameter int DEPTH = 96,
  parameter int ROWS = 12,
  parameter int SCAN_TAP = 4
) (
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic [31:0] HRDATA_O,
  output logic HRESP_O,
  output logic PUMP_CLK_O,
  output logic PUMP_EN_O,
  output logic REG_EN_O,
  output logic [1:0] REG_LEVEL_O,
  output logic [ROWS-1:0] PANEL_ROW_DRIVE_O,
  output logic [lcd_pkg::COL_W-1:0] PANEL_COLUMN_DRIVE_O
);

  if (DEPTH < lcd_pkg::MIN_DEPTH || DEPTH > lcd_pkg::MAX_DEPTH ||
      DEPTH % lcd_pkg::BYTES_PER_ROW != 0) begin : bad_depth
    $error("DEPTH must be a multiple of 8 from 8 to 96");
  end
  if (ROWS < 2 || ROWS > lcd_pkg::MAX_ROWS ||
      ROWS * lcd_pkg::BYTES_PER_ROW > DEPTH) begin : bad_rows
    $error("ROWS must be 2 to 12 and fit in DEPTH");
  end
  if (SCAN_TAP < 0 || SCAN_TAP >= lcd_pkg::TAP_W) begin : bad_tap
    $error("SCAN_TAP must name a divider tap");
  end

  localparam logic [lcd_pkg::ROW_W-1:0] ROW_LAST = lcd_pkg::ROW_W'(ROWS - 1);
  localparam logic [ROWS-1:0] ROW_ONE = {{(ROWS-1){1'b0}}, 1'b1};

  // Slow clock made as a square wave from the system clock
  logic [lcd_pkg::HALF_W-1:0] half_cnt_r;
  logic slow_clk_r;
  logic slow_rise;
  logic [lcd_pkg::TAP_W-1:0] slow_divider_tap_r;
  logic [lcd_pkg::TAP_W-1:0] tap_nxt;

  // Bus and register state
  logic accept;
  logic ph_valid_r;
  logic ph_write_r;
  logic ph_ok_r;
  logic [lcd_pkg::IDX_W-1:0] ph_idx_r;
  logic [lcd_pkg::IDX_W-1:0] ram_off;
  logic hit_ctrl;
  logic hit_ram;
  logic ram_we;
  logic [31:0] rd_mux;
  logic hready_r;
  logic [31:0] hrdata_r;
  logic hresp_r;
  logic [7:0] display_power_control_r;

  // Pump clock selection
  logic [2:0] sel_code;
  logic [2:0] tap_idx;
  logic sel_clk;
  logic pump_clk_r;

  // Panel scanner
  lcd_pkg::scan_state_t scan_state_r;
  logic row_tick;
  logic [lcd_pkg::ROW_W-1:0] cur_row_r;
  logic [lcd_pkg::ROW_W-1:0] fill_row_r;
  logic [2:0] fill_cnt_r;
  logic fill_done;
  logic [7:0] shadow_r [lcd_pkg::BYTES_PER_ROW];
  logic [lcd_pkg::COL_W-1:0] col_nxt;
  logic [ROWS-1:0] row_drive_r;
  logic [lcd_pkg::COL_W-1:0] col_drive_r;
  logic [lcd_pkg::RAM_AW-1:0] scan_addr;
  logic [7:0] scan_rdata;
  logic [7:0] cpu_rdata;

  assign slow_rise = (half_cnt_r == lcd_pkg::SLOW_HALF_LAST) && !slow_clk_r;
  assign tap_nxt = slow_divider_tap_r + 1'b1;

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      half_cnt_r <= '0;
      slow_clk_r <= 1'b0;
    end else if (half_cnt_r == lcd_pkg::SLOW_HALF_LAST) begin
      half_cnt_r <= '0;
      slow_clk_r <= ~slow_clk_r;
    end else begin
      half_cnt_r <= half_cnt_r + 1'b1;
    end
  end

  // Tap k toggles at the slow rate over 2^(k+1)
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      slow_divider_tap_r <= '0;
    end else if (slow_rise) begin
      slow_divider_tap_r <= tap_nxt;
    end
  end

  // Address phase capture; every transfer gets one wait state
  assign accept = HSEL_I && HTRANS_I[lcd_pkg::HTRANS_ACTIVE_BIT] && HREADY_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_ok_r <= 1'b0;
      ph_idx_r <= '0;
    end else if (accept) begin
      ph_valid_r <= 1'b1;
      ph_write_r <= HWRITE_I;
      ph_ok_r <= (HADDR_I[31:lcd_pkg::IDX_MSB+1] == '0) &&
                 (HADDR_I[lcd_pkg::IDX_LSB-1:0] == '0);
      ph_idx_r <= HADDR_I[lcd_pkg::IDX_MSB:lcd_pkg::IDX_LSB];
    end else begin
      ph_valid_r <= 1'b0;
    end
  end

  assign ram_off = ph_idx_r - lcd_pkg::IDX_DISP_BASE;
  assign hit_ctrl = ph_ok_r && (ph_idx_r == lcd_pkg::IDX_POWER_CTRL);
  assign hit_ram = ph_ok_r && (ph_idx_r >= lcd_pkg::IDX_DISP_BASE) &&
                   (ph_idx_r <= lcd_pkg::IDX_DISP_TOP) &&
                   (int'(ram_off) < DEPTH);
  // Write goes straight into the buffer, no handshake with the scanner
  assign ram_we = ph_valid_r && ph_write_r && hit_ram;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = {24'h00_0000, display_power_control_r};
    end else if (hit_ram) begin
      rd_mux = {24'h00_0000, cpu_rdata};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      hready_r <= 1'b1;
    end else begin
      hready_r <= !accept;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ph_valid_r && !ph_write_r) begin
      hrdata_r <= rd_mux;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= lcd_pkg::HRESP_OKAY;
    end
  end

  // Bit 7 is reserved and always reads zero
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      display_power_control_r <= lcd_pkg::POWER_CTRL_RESET;
    end else if (ph_valid_r && ph_write_r && hit_ctrl) begin
      display_power_control_r <= HWDATA_I[7:0] & lcd_pkg::POWER_CTRL_MASK;
    end
  end

  // Code 000 picks tap 6, each step up halves the divisor
  assign sel_code = display_power_control_r[lcd_pkg::PC_SEL_MSB:lcd_pkg::PC_SEL_LSB];
  assign tap_idx = lcd_pkg::PUMP_TAP_TOP - sel_code;
  assign sel_clk = (sel_code == lcd_pkg::PUMP_SEL_DIRECT) ? slow_clk_r :
                   slow_divider_tap_r[tap_idx];

  // Glitches on a select change are harmless to a charge pump
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      pump_clk_r <= 1'b0;
    end else begin
      pump_clk_r <= display_power_control_r[lcd_pkg::PC_PUMP_EN] && sel_clk;
    end
  end

  // Row timing from a divider tap; frame rate control lives elsewhere
  assign row_tick = slow_rise && tap_nxt[SCAN_TAP] && !slow_divider_tap_r[SCAN_TAP];
  assign fill_done = (scan_state_r == lcd_pkg::SCAN_FILL) && (fill_cnt_r == 3'h7);
  // Full row index: rows 8 to 11 sit above the first 64 bytes
  assign scan_addr = {fill_row_r, fill_cnt_r};

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      scan_state_r <= lcd_pkg::SCAN_IDLE;
      fill_row_r <= '0;
      fill_cnt_r <= 3'h0;
    end else begin
      case (scan_state_r)
        lcd_pkg::SCAN_IDLE: begin
          if (row_tick) begin
            scan_state_r <= lcd_pkg::SCAN_FILL;
            fill_row_r <= (cur_row_r == ROW_LAST) ? '0 : cur_row_r + 1'b1;
            fill_cnt_r <= 3'h0;
          end
        end
        lcd_pkg::SCAN_FILL: begin
          fill_cnt_r <= fill_cnt_r + 1'b1;
          if (fill_done) begin
            scan_state_r <= lcd_pkg::SCAN_IDLE;
          end
        end
        default: begin
          scan_state_r <= lcd_pkg::SCAN_IDLE;
        end
      endcase
    end
  end

  // One shadow byte per column group; the last byte is taken live
  for (genvar k = 0; k < lcd_pkg::BYTES_PER_ROW; k++) begin : g_group
    always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
        shadow_r[k] <= 8'h00;
      end else if ((scan_state_r == lcd_pkg::SCAN_FILL) && (fill_cnt_r == 3'(k))) begin
        shadow_r[k] <= scan_rdata;
      end
    end
    if (k == lcd_pkg::BYTES_PER_ROW - 1) begin : g_live
      assign col_nxt[8*k +: 8] = scan_rdata;
    end else begin : g_held
      assign col_nxt[8*k +: 8] = shadow_r[k];
    end
  end

  // Row and columns switch together so a row never shows stale columns
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      cur_row_r <= ROW_LAST;
      row_drive_r <= '0;
      col_drive_r <= '0;
    end else if (fill_done) begin
      cur_row_r <= fill_row_r;
      row_drive_r <= ROW_ONE << fill_row_r;
      col_drive_r <= col_nxt;
    end
  end

  display_buffer_ram #(
    .DEPTH(DEPTH)
  ) u_display_buffer_ram (
    .clk_i(SYS_CLK_I),
    .cpu_we_i(ram_we),
    .cpu_addr_i(ram_off[lcd_pkg::RAM_AW-1:0]),
    .cpu_wdata_i(HWDATA_I[7:0]),
    .cpu_rdata_o(cpu_rdata),
    .scan_addr_i(scan_addr),
    .scan_rdata_o(scan_rdata)
  );

  assign HREADYOUT_O = hready_r;
  assign HRDATA_O = hrdata_r;
  assign HRESP_O = hresp_r;
  assign PUMP_CLK_O = pump_clk_r;
  assign PUMP_EN_O = display_power_control_r[lcd_pkg::PC_PUMP_EN];
  assign REG_EN_O = display_power_control_r[lcd_pkg::PC_REG_EN];
  // Level is 1 V plus 0.167 V per code
  assign REG_LEVEL_O = display_power_control_r[lcd_pkg::PC_LVL_MSB:lcd_pkg::PC_LVL_LSB];
  assign PANEL_ROW_DRIVE_O = row_drive_r;
  assign PANEL_COLUMN_DRIVE_O = col_drive_r;

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence ctrl_write_s;
    ph_valid_r && ph_write_r && hit_ctrl;
  endsequence

  sequence fill_start_s;
    (scan_state_r == lcd_pkg::SCAN_FILL) && (fill_cnt_r == 3'h0);
  endsequence

  pump_off_a: assert property (
    !display_power_control_r[lcd_pkg::PC_PUMP_EN] |=> !PUMP_CLK_O)
    else $error("Pump clock runs while pump disabled");

  pump_tap_a: assert property (
    display_power_control_r[lcd_pkg::PC_PUMP_EN] && (sel_code == 3'h0) |=>
      PUMP_CLK_O == $past(slow_divider_tap_r[6]))
    else $error("Code 000 does not give tap 6");

  pump_direct_a: assert property (
    display_power_control_r[lcd_pkg::PC_PUMP_EN] && (sel_code == 3'h7) |=>
      PUMP_CLK_O == $past(slow_clk_r))
    else $error("Code 111 does not give slow clock");

  reg_enable_a: assert property (
    ctrl_write_s |=> REG_EN_O == $past(HWDATA_I[4]))
    else $error("Regulator enable not taken from bit 4");

  reg_level_a: assert property (
    ctrl_write_s |=> REG_LEVEL_O == $past(HWDATA_I[6:5]) ##1 $stable(REG_LEVEL_O))
    else $error("Regulator level not taken from bits 6:5");

  row_onehot_a: assert property (
    fill_done |=> $onehot(PANEL_ROW_DRIVE_O) &&
      PANEL_ROW_DRIVE_O[$past(fill_row_r)])
    else $error("Row drive is not the filled row");

  col_group_a: assert property (
    fill_start_s |-> ##8 PANEL_COLUMN_DRIVE_O[7:0] === $past(scan_rdata, 8))
    else $error("Byte 0 did not reach column group 0");

  bus_wait_a: assert property (
    accept |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("Transfer did not take exactly one wait state");

  ram_addr_a: assert property (
    fill_start_s |-> scan_addr == {fill_row_r, 3'h0})
    else $error("Scanner address does not start row at offset 0");

endmodule

// ---- test/panel_model.sv ----
// Passive model of the display glass: keeps the column image per row line.
// Assumes one-hot row drive from the block, sampled on the system clock.
`timescale 1ns/1ns
module panel_model #(
  parameter int ROWS = 12
) (
  input wire logic clk_i,
  input wire logic [ROWS-1:0] row_i,
  input wire logic [63:0] col_i
);
  logic [63:0] seen [ROWS];
  logic [ROWS-1:0] last = '0;
  logic [ROWS-1:0] next_row;
  int fills = 0;
  logic order_bad = 1'b0;

  // Blank drive is followed by row 0, otherwise rows rotate upwards
  assign next_row = (last == '0) ? ROWS'(1) : {last[ROWS-2:0], last[ROWS-1]};

  always @(posedge clk_i) begin
    for (int r = 0; r < ROWS; r++) begin
      if (row_i[r] === 1'b1) begin
        seen[r] <= col_i;
      end
    end
    // Drive before and during reset is not a row change
    if ((row_i !== last) && $onehot(row_i)) begin
      fills <= fills + 1;
      last <= row_i;
      if (row_i !== next_row) begin
        order_bad <= 1'b1;
      end
    end
  end
endmodule

// ---- test/lcd_power_and_display_ram_bench.sv ----
// Self-checking bench for display power control and buffer scan.
// Assumes an AHB-Lite master of single word transfers and a passive panel.
`timescale 1ns/1ns
module lcd_power_and_display_ram_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic pump_clk;
  logic pump_en;
  logic reg_en;
  logic [1:0] reg_level;
  logic [11:0] rows;
  logic [63:0] cols;
  logic [31:0] rd;
  int miscompares = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  // Fastest scan tap keeps a full frame near seven thousand three hundred cycles
  lcd_power_and_display_ram #(.DEPTH(96), .ROWS(12), .SCAN_TAP(0)) u_lcd_power_and_display_ram (
    .SYS_CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp), .PUMP_CLK_O(pump_clk),
    .PUMP_EN_O(pump_en), .REG_EN_O(reg_en), .REG_LEVEL_O(reg_level),
    .PANEL_ROW_DRIVE_O(rows), .PANEL_COLUMN_DRIVE_O(cols));

  panel_model #(.ROWS(12)) u_panel_model (.clk_i(clk), .row_i(rows), .col_i(cols));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up(input string what);
    miscompares++;
    $display("[FAIL] %s expected done seen timeout", what);
    print_verdict;
  endtask

  // Level before a rising edge equals the level at the negedge before it
  task automatic wait_ready;
    int n;
    n = 0;
    @(negedge clk);
    while (hready !== 1'b1) begin
      if (n == 20) begin
        give_up("bus ready");
      end
      @(negedge clk);
      n++;
    end
    rd = hrdata;
    @(posedge clk);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, 64'(rd), 64'(exp));
  endtask

  task automatic wait_fills(input int k);
    int start;
    int n;
    start = u_panel_model.fills;
    n = 0;
    while (u_panel_model.fills < start + k) begin
      if (n == 20000) begin
        give_up("row scan");
      end
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_pump(input logic v, output int cnt);
    cnt = 0;
    while (pump_clk !== v) begin
      if (cnt == 40000) begin
        give_up("pump clock");
      end
      @(negedge clk);
      cnt++;
    end
  endtask

  function automatic logic [7:0] pat(input int b);
    return 8'(b * 29 + 17);
  endfunction

  function automatic logic [63:0] row_img(input int r);
    logic [63:0] e;
    for (int k = 0; k < 8; k++) begin
      e[8*k +: 8] = pat(r * 8 + k);
    end
    return e;
  endfunction

  task automatic reset_values;
    rd_chk("power ctrl reset", 32'h68, 32'h6f);
    @(negedge clk);
    check("pump en reset", 64'(pump_en), 64'h1);
    check("reg en reset", 64'(reg_en), 64'h0);
    check("level reset", 64'(reg_level), 64'h3);
    check("bus response", 64'(hresp), 64'h0);
  endtask

  task automatic power_sequence;
    int hi;
    wr(32'h68, 32'h7f);
    @(negedge clk);
    check("reg en on", 64'(reg_en), 64'h1);
    for (int lvl = 0; lvl < 4; lvl++) begin
      wr(32'h68, 32'({2'(lvl), 5'h1f}));
      rd_chk("level readback", 32'h68, 32'({2'(lvl), 5'h1f}));
      check("level out", 64'(reg_level), 64'(lvl));
    end
    // Power down in reverse order: pump, then regulator
    wr(32'h68, 32'h77);
    @(negedge clk);
    check("pump en off", 64'(pump_en), 64'h0);
    hi = 0;
    repeat (700) begin
      @(negedge clk);
      hi += int'(pump_clk === 1'b1);
    end
    check("pump clock idle", 64'(hi), 64'h0);
    wr(32'h68, 32'h67);
    @(negedge clk);
    check("reg en off", 64'(reg_en), 64'h0);
    wr(32'h68, 32'hff);
    rd_chk("top bit dropped", 32'h68, 32'h7f);
  endtask

  task automatic display_scan;
    for (int b = 0; b < 96; b++) begin
      wr(32'h800 + 32'(4 * b), 32'(pat(b)));
    end
    wait_fills(13);
    for (int r = 0; r < 12; r++) begin
      check("row columns", u_panel_model.seen[r], row_img(r));
    end
    check("row order", 64'(u_panel_model.order_bad), 64'h0);
    rd_chk("buffer top byte", 32'h97c, 32'(pat(95)));
    rd_chk("buffer first byte", 32'h800, 32'(pat(0)));
    wr(32'h980, 32'ha5);
    rd_chk("past buffer top", 32'h980, 32'h0);
  endtask

  task automatic scan_update;
    logic [63:0] e;
    // Row 5 byte 3 is rewritten while the scan runs
    wr(32'h800 + 32'(4 * 43), 32'hc3);
    wait_fills(13);
    e = row_img(5);
    e[31:24] = 8'hc3;
    check("updated row", u_panel_model.seen[5], e);
  endtask

  // Slowest two codes are only set and read back to bound the run time
  task automatic pump_rates;
    int cnt;
    for (int c = 0; c < 8; c++) begin
      wr(32'h68, 32'h78 | 32'(c));
      rd_chk("pump select", 32'h68, 32'h78 | 32'(c));
      if (c >= 2) begin
        @(negedge clk);
        wait_pump(1'b1, cnt);
        wait_pump(1'b0, cnt);
        wait_pump(1'b1, cnt);
        check("pump half period", 64'(cnt), 64'(lcd_pkg::SLOW_HALF_CYC << (7 - c)));
      end
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    reset_values;
    power_sequence;
    display_scan;
    scan_update;
    pump_rates;
    print_verdict;
  end
endmodule
